/* File: include/timer_pkg.sv */
// Constants, register map and carrier types of the dual timer/counter core.
// Assumes a byte-wide register port and a one-clock design at 10 MHz.
package timer_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h88;
    localparam logic [7:0] ADDR_MODE    = 8'h89;
    localparam logic [7:0] ADDR_A_LO    = 8'h8a;
    localparam logic [7:0] ADDR_B_LO    = 8'h8b;
    localparam logic [7:0] ADDR_A_HI    = 8'h8c;
    localparam logic [7:0] ADDR_B_HI    = 8'h8d;
    localparam logic [7:0] ADDR_EXT     = 8'h91;
    localparam logic [7:0] ADDR_CLKCFG  = 8'h96;
    localparam logic [7:0] ADDR_M0W     = 8'h97;
    localparam logic [7:0] ADDR_A_RLO   = 8'hf2;
    localparam logic [7:0] ADDR_B_RLO   = 8'hf3;
    localparam logic [7:0] ADDR_A_RHI   = 8'hf4;
    localparam logic [7:0] ADDR_B_RHI   = 8'hf5;
    // Bit addresses of the control register carry this base in bits 7:3 plus 0..7.
    localparam logic [4:0] BIT_CTRL_BASE = 5'h11;

    // ------------------------------------------------------------------
    // Field positions, index 0 is timer A or interrupt A
    // ------------------------------------------------------------------
    localparam logic [1:0][2:0] OVF_POS  = {3'h7, 3'h5};
    localparam logic [1:0][2:0] RUN_POS  = {3'h6, 3'h4};
    localparam logic [1:0][2:0] EIF_POS  = {3'h3, 3'h1};
    localparam logic [1:0][2:0] EIT_POS  = {3'h2, 3'h0};
    localparam logic [1:0][2:0] HALF_POS = {3'h5, 3'h4};
    localparam logic [1:0][2:0] TOG_POS  = {3'h1, 3'h0};
    localparam logic [1:0][2:0] PWM_POS  = {3'h3, 3'h2};
    localparam int              NIB_W    = 4;
    localparam int              GATE_POS = 3;
    localparam int              SEL_POS  = 2;
    localparam logic [2:0]      M0W_MAX  = 3'h7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [7:0] CLKCFG_RESET = 8'h05;
    localparam logic [7:0] M0W_RESET    = 8'h44;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam logic [7:0] FULL_BYTE    = 8'hff;

    // Operating modes in the order of the two-bit mode field.
    typedef enum logic [1:0] {
        MODE_13, MODE_16, MODE_RELOAD8, MODE_SPLIT
    } timer_mode_t;

    // Byte access from software.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // Single-bit write to a bit-addressable register.
    typedef struct packed {
        logic [7:0] addr;
        logic       val;
        logic       wr;
    } bit_req_t;

    // Whole state of the core.
    typedef struct packed {
        logic [1:0][7:0] cntLo;
        logic [1:0][7:0] cntHi;
        logic [1:0][7:0] rldLo;
        logic [1:0][7:0] rldHi;
        logic [1:0][7:0] pwmPre;
        logic [1:0][7:0] pwmCnt;
        logic [7:0]      ctrl;
        logic [7:0]      mode;
        logic [7:0]      ext;
        logic [7:0]      clkCfg;
        logic [7:0]      m0w;
        logic [7:0]      rdData;
        logic [3:0]      presc;
        logic [1:0]      half;
        logic [1:0]      pinPrev;
        logic [1:0]      irqPrev;
        logic [1:0]      toggle;
        logic [1:0]      pwmOut;
    } core_state_t;

endpackage : timer_pkg

/* File: hw/dual_timer_counter_core.sv */
// Two 16-bit timer/counters with shared prescaler, gating, toggle and PWM outputs.
// Assumes all pins and strobes are synchronous to clock and strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter_core
    import timer_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       nrst,
    // Register port.
    input  wire reg_req_t   regReq,
    input  wire bit_req_t   bitReq,
    output logic [7:0]      regRdData,
    // Clocking configuration.
    input  wire logic       compatMode,
    input  wire logic       doubleSpeed,
    // Acknowledges from the interrupt controller, bit 0 is A.
    input  wire logic [1:0] timerVectorAck,
    input  wire logic [1:0] extIrqAck,
    // Pins, bit 0 is A.
    input  wire logic [1:0] countPin,
    input  wire logic [1:0] extIrqPin,
    output logic [1:0]      togglePin,
    output logic [1:0]      pwmPin,
    // Flags towards the interrupt controller.
    output logic [1:0]      overflowFlag,
    output logic [1:0]      extIrqFlag
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Mask of the low-byte prescaler bits in mode 0, width is field plus one.
    function automatic logic [7:0] m0Mask(input logic [2:0] w);
        m0Mask = FULL_BYTE >> (M0W_MAX - w);
    endfunction : m0Mask

    core_state_t r;
    core_state_t s;
    logic        presTick;
    logic [1:0]  tick;
    logic [1:0]  edgeHit;
    logic [1:0]  incEn;
    logic [1:0]  ovfHit;
    logic        splitHiOvf;
    logic        anyWr;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Computes counting, flags, PWM and register access for one cycle.
    always_comb begin : next_state
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [7:0]  mask;
        logic [3:0]  nib;
        logic        sampleEn;
        logic        halfBit;
        logic        runOk;
        logic        irqSet;
        timer_mode_t md;
        lo = ZERO_BYTE;
        hi = ZERO_BYTE;
        mask = ZERO_BYTE;
        nib = 4'h0;
        sampleEn = 1'b0;
        halfBit = 1'b0;
        runOk = 1'b0;
        irqSet = 1'b0;
        md = MODE_13;
        s = r;
        tick = 2'h0;
        edgeHit = 2'h0;
        incEn = 2'h0;
        ovfHit = 2'h0;
        splitHiOvf = 1'b0;
        anyWr = regReq.wr | bitReq.wr;
        s.rdData = ZERO_BYTE;

        // Shared prescaler wraps after setting plus one clocks.
        // A setting lowered below the running count wraps at once, so the
        // new rate holds from the next clock instead of after a full lap.
        presTick = (r.presc >= r.clkCfg[3:0]);
        s.presc = presTick ? 4'h0 : r.presc + 4'h1;

        for (int i = 0; i < 2; i++) begin
            halfBit = r.clkCfg[HALF_POS[i]];
            if (compatMode) begin
                if (doubleSpeed && halfBit) begin
                    tick[i] = presTick & r.half[i];
                    if (presTick) begin
                        s.half[i] = ~r.half[i];
                    end
                end else begin
                    tick[i] = presTick;
                end
                sampleEn = tick[i];
            end else begin
                tick[i] = halfBit ? presTick : 1'b1;
                sampleEn = 1'b1;
            end

            // Falling edge seen between two samples of the count pin.
            if (sampleEn) begin
                s.pinPrev[i] = countPin[i];
            end
            edgeHit[i] = sampleEn & r.pinPrev[i] & ~countPin[i];

            nib = r.mode[NIB_W*i +: NIB_W];
            md = timer_mode_t'(nib[1:0]);
            runOk = r.ctrl[RUN_POS[i]] & (~nib[GATE_POS] | extIrqPin[i]);
            incEn[i] = runOk & (nib[SEL_POS] ? edgeHit[i] : tick[i]);
            lo = r.cntLo[i];
            hi = r.cntHi[i];

            // Count by mode; without an increment the count holds.
            unique case (md)
                MODE_13: begin
                    mask = m0Mask(r.m0w[NIB_W*i +: 3]);
                    if (incEn[i]) begin
                        if ((lo & mask) == mask) begin
                            lo = lo & ~mask;
                            ovfHit[i] = (hi == FULL_BYTE);
                            hi = hi + 8'h01;
                        end else begin
                            lo = (lo & ~mask) | ((lo + 8'h01) & mask);
                        end
                    end
                end
                MODE_16: begin
                    if (incEn[i]) begin
                        if ({hi, lo} == {FULL_BYTE, FULL_BYTE}) begin
                            {hi, lo} = {r.rldHi[i], r.rldLo[i]};
                            ovfHit[i] = 1'b1;
                        end else begin
                            {hi, lo} = {hi, lo} + 16'h0001;
                        end
                    end
                end
                MODE_RELOAD8: begin
                    if (incEn[i]) begin
                        if (lo == FULL_BYTE) begin
                            lo = hi;
                            ovfHit[i] = 1'b1;
                        end else begin
                            lo = lo + 8'h01;
                        end
                    end
                end
                MODE_SPLIT: begin
                    // Timer A splits in two bytes; timer B halts here.
                    if (i == 0) begin
                        if (incEn[i]) begin
                            ovfHit[i] = (lo == FULL_BYTE);
                            lo = lo + 8'h01;
                        end
                        if (tick[i] && r.ctrl[RUN_POS[1]]) begin
                            splitHiOvf = (hi == FULL_BYTE);
                            hi = hi + 8'h01;
                        end
                    end
                end
            endcase
            s.cntLo[i] = lo;
            s.cntHi[i] = hi;

            // Output pin toggles on each overflow when enabled.
            if (ovfHit[i] && r.ext[TOG_POS[i]]) begin
                s.toggle[i] = ~r.toggle[i];
            end

            // PWM: reload high prescales, reload low sets the duty.
            if (r.ext[PWM_POS[i]]) begin
                if (r.pwmPre[i] >= r.rldHi[i]) begin
                    s.pwmPre[i] = ZERO_BYTE;
                    s.pwmCnt[i] = r.pwmCnt[i] + 8'h01;
                end else begin
                    s.pwmPre[i] = r.pwmPre[i] + 8'h01;
                end
                s.pwmOut[i] = (r.pwmCnt[i] < r.rldLo[i]);
            end else begin
                s.pwmPre[i] = ZERO_BYTE;
                s.pwmCnt[i] = ZERO_BYTE;
                s.pwmOut[i] = 1'b0;
            end
        end

        // Byte writes from software; a write replaces the count.
        if (regReq.wr) begin
            unique case (regReq.addr)
                ADDR_CTRL:   s.ctrl = regReq.wrData;
                ADDR_MODE:   s.mode = regReq.wrData;
                ADDR_A_LO:   s.cntLo[0] = regReq.wrData;
                ADDR_B_LO:   s.cntLo[1] = regReq.wrData;
                ADDR_A_HI:   s.cntHi[0] = regReq.wrData;
                ADDR_B_HI:   s.cntHi[1] = regReq.wrData;
                ADDR_EXT:    s.ext = regReq.wrData;
                ADDR_CLKCFG: s.clkCfg = regReq.wrData;
                ADDR_M0W:    s.m0w = regReq.wrData;
                ADDR_A_RLO:  s.rldLo[0] = regReq.wrData;
                ADDR_B_RLO:  s.rldLo[1] = regReq.wrData;
                ADDR_A_RHI:  s.rldHi[0] = regReq.wrData;
                ADDR_B_RHI:  s.rldHi[1] = regReq.wrData;
                default:     s.ctrl = s.ctrl;
            endcase
        end

        // Single-bit writes to the control register.
        if (bitReq.wr && bitReq.addr[7:3] == BIT_CTRL_BASE) begin
            s.ctrl[bitReq.addr[2:0]] = bitReq.val;
        end

        // Flags: clear by acknowledge, then hardware set wins.
        for (int j = 0; j < 2; j++) begin
            if (timerVectorAck[j]) begin
                s.ctrl[OVF_POS[j]] = 1'b0;
            end
            s.irqPrev[j] = extIrqPin[j];
            irqSet = r.ctrl[EIT_POS[j]] ? (r.irqPrev[j] & ~extIrqPin[j])
                                        : ~extIrqPin[j];
            if (extIrqAck[j]) begin
                s.ctrl[EIF_POS[j]] = 1'b0;
            end
            if (irqSet) begin
                s.ctrl[EIF_POS[j]] = 1'b1;
            end
        end
        // Only timer A's own overflow sets its flag; the split high byte
        // reports through timer B's flag, and timer B's own overflow then does not set it.
        if (ovfHit[0]) begin
            s.ctrl[OVF_POS[0]] = 1'b1;
        end
        if (splitHiOvf || (ovfHit[1] && r.mode[1:0] != MODE_SPLIT)) begin
            s.ctrl[OVF_POS[1]] = 1'b1;
        end

        // Read data appears in the cycle after the strobe.
        if (regReq.rd) begin
            unique case (regReq.addr)
                ADDR_CTRL:   s.rdData = r.ctrl;
                ADDR_MODE:   s.rdData = r.mode;
                ADDR_A_LO:   s.rdData = r.cntLo[0];
                ADDR_B_LO:   s.rdData = r.cntLo[1];
                ADDR_A_HI:   s.rdData = r.cntHi[0];
                ADDR_B_HI:   s.rdData = r.cntHi[1];
                ADDR_EXT:    s.rdData = r.ext;
                ADDR_CLKCFG: s.rdData = r.clkCfg;
                ADDR_M0W:    s.rdData = r.m0w;
                ADDR_A_RLO:  s.rdData = r.rldLo[0];
                ADDR_B_RLO:  s.rdData = r.rldLo[1];
                ADDR_A_RHI:  s.rdData = r.rldHi[0];
                ADDR_B_RHI:  s.rdData = r.rldHi[1];
                default:     s.rdData = ZERO_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Registers the whole state; reset loads constants only.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.ctrl <= CTRL_RESET;
            r.mode <= MODE_RESET;
            r.clkCfg <= CLKCFG_RESET;
            r.m0w <= M0W_RESET;
        end else begin
            r <= s;
        end
    end

    // Outputs come straight from state flip-flops.
    assign regRdData = r.rdData;
    assign togglePin = r.toggle;
    assign pwmPin = r.pwmOut;
    assign overflowFlag = {r.ctrl[OVF_POS[1]], r.ctrl[OVF_POS[0]]};
    assign extIrqFlag = {r.ctrl[EIF_POS[1]], r.ctrl[EIF_POS[0]]};

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    presc_wrap_a: assert property (@(posedge clock) disable iff (!nrst)
        (presTick && !regReq.wr) |=> (r.presc == 4'h0))
        else $error("Prescaler did not wrap at its setting.");

    fast_count_a: assert property (@(posedge clock) disable iff (!nrst)
        (!compatMode && !r.clkCfg[HALF_POS[0]] && r.ctrl[RUN_POS[0]]
         && r.mode[3:0] == 4'h1 && !anyWr && {r.cntHi[0], r.cntLo[0]} != 16'hffff)
        |=> ({r.cntHi[0], r.cntLo[0]} == $past({r.cntHi[0], r.cntLo[0]}) + 16'h0001))
        else $error("Fast mode timer did not count every clock.");

    compat_rate_a: assert property (@(posedge clock) disable iff (!nrst)
        (compatMode && r.clkCfg[3:0] == 4'h5 && !regReq.wr && presTick)
        |=> !presTick [*5] ##1 presTick)
        else $error("Compatibility tick not every six clocks.");

    edge_count_a: assert property (@(posedge clock) disable iff (!nrst)
        (!compatMode && r.mode[3:0] == 4'h5 && r.ctrl[RUN_POS[0]] && r.pinPrev[0]
         && !countPin[0] && !anyWr && {r.cntHi[0], r.cntLo[0]} != 16'hffff)
        |=> ({r.cntHi[0], r.cntLo[0]} == $past({r.cntHi[0], r.cntLo[0]}) + 16'h0001))
        else $error("Falling edge did not advance the counter.");

    stop_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        (!r.ctrl[RUN_POS[1]] && !anyWr && r.mode[5:4] != MODE_SPLIT)
        |=> ($stable(r.cntLo[1]) && $stable(r.cntHi[1])))
        else $error("Stopped timer changed its count.");

    gate_halt_a: assert property (@(posedge clock) disable iff (!nrst)
        (r.mode[GATE_POS] && !extIrqPin[0]) |-> !incEn[0])
        else $error("Gated timer counted with its pin low.");

    ovf_flag_a: assert property (@(posedge clock) disable iff (!nrst)
        ovfHit[0] |=> overflowFlag[0])
        else $error("Overflow did not set the flag.");

    ovf_clear_a: assert property (@(posedge clock) disable iff (!nrst)
        (timerVectorAck[0] && !ovfHit[0] && !anyWr) |=> !overflowFlag[0])
        else $error("Acknowledge did not clear the overflow flag.");

    toggle_pin_a: assert property (@(posedge clock) disable iff (!nrst)
        (ovfHit[1] && r.ext[TOG_POS[1]]) |=> (togglePin[1] != $past(togglePin[1])))
        else $error("Overflow did not toggle the pin.");

    ext_level_a: assert property (@(posedge clock) disable iff (!nrst)
        (!r.ctrl[EIT_POS[0]] && !extIrqPin[0]) |=> extIrqFlag[0])
        else $error("Low level did not set the interrupt flag.");

    ext_edge_a: assert property (@(posedge clock) disable iff (!nrst)
        (r.ctrl[EIT_POS[1]] && r.irqPrev[1] && !extIrqPin[1]) |=> extIrqFlag[1])
        else $error("Falling edge did not set the interrupt flag.");

    reload_eight_a: assert property (@(posedge clock) disable iff (!nrst)
        (incEn[0] && r.mode[1:0] == MODE_RELOAD8 && r.cntLo[0] == 8'hff && !anyWr)
        |=> (r.cntLo[0] == $past(r.cntHi[0])))
        else $error("Auto-reload did not load the high byte.");

endmodule : dual_timer_counter_core

`default_nettype wire

/* File: bench/pin_source.sv */
// Model of the count and gate pins that sit outside the timer core.
// Assumes the bench calls its tasks; pins change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    // Clock.
    input  wire logic  clock,
    // Pins, bit 0 is timer A.
    output logic [1:0] countPin,
    output logic [1:0] extIrqPin
);
    // Idle pins rest high, as a pull-up would leave them.
    initial begin
        countPin  = 2'h3;
        extIrqPin = 2'h3;
    end

    // One falling then rising count edge, each level held for hold clocks.
    task automatic pulse(input int idx, input int hold);
        @(posedge clock);
        countPin[idx] <= 1'b0;
        repeat (hold) @(posedge clock);
        countPin[idx] <= 1'b1;
        repeat (hold) @(posedge clock);
    endtask : pulse

    // Drives a gate or interrupt pin and holds it for hold clocks.
    task automatic gate(input int idx, input logic lvl, input int hold);
        @(posedge clock);
        extIrqPin[idx] <= lvl;
        repeat (hold) @(posedge clock);
    endtask : gate
endmodule : pin_source
`default_nettype wire

/* File: bench/dual_timer_counter_core_tb.sv */
// Self-checking bench of the dual timer/counter core.
// Assumes the pin model drives the count and gate pins.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_core_tb
    import timer_pkg::*;
;
    logic       clock;
    logic       nrst;
    reg_req_t   regReq;
    bit_req_t   bitReq;
    logic [7:0] regRdData;
    logic       compatMode;
    logic       doubleSpeed;
    logic [1:0] timerVectorAck;
    logic [1:0] extIrqAck;
    logic [1:0] countPin;
    logic [1:0] extIrqPin;
    logic [1:0] togglePin;
    logic [1:0] pwmPin;
    logic [1:0] overflowFlag;
    logic [1:0] extIrqFlag;
    int         n_mismatch = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         nHigh;
    logic [7:0] lo0;
    logic [7:0] lo1;
    // Rate cases: mode, double speed, clock config, window, counts.
    logic       cm[5] = '{0, 0, 0, 1, 1};
    logic       ds[5] = '{0, 0, 0, 0, 1};
    logic [7:0] cf[5] = '{8'h05, 8'h13, 8'h1f, 8'h05, 8'h15};
    int         kk[5] = '{40, 40, 160, 60, 120};
    logic [7:0] ex[5] = '{8'h28, 8'h0a, 8'h0a, 8'h0a, 8'h0a};

    dual_timer_counter_core dual_timer_counter_core_i (
        .clock(clock), .nrst(nrst), .regReq(regReq), .bitReq(bitReq),
        .regRdData(regRdData), .compatMode(compatMode), .doubleSpeed(doubleSpeed),
        .timerVectorAck(timerVectorAck), .extIrqAck(extIrqAck), .countPin(countPin),
        .extIrqPin(extIrqPin), .togglePin(togglePin), .pwmPin(pwmPin),
        .overflowFlag(overflowFlag), .extIrqFlag(extIrqFlag));
    pin_source pin_source_i (.clock(clock), .countPin(countPin), .extIrqPin(extIrqPin));

    // Free-running 10 MHz clock.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Cuts a hang short well beyond the thousand or so cycles the tests need.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Waits n edges, then lets that edge's updates settle.
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        regReq.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        regReq.rd <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rc

    // Writes one bit of the control register.
    task automatic bw(input logic [2:0] b, input logic v);
        @(posedge clock);
        bitReq <= '{8'h88 + b, v, 1'b1};
        @(posedge clock);
        bitReq.wr <= 1'b0;
    endtask : bw

    task automatic ack(input logic [1:0] t, input logic [1:0] e);
        @(posedge clock);
        timerVectorAck <= t;
        extIrqAck      <= e;
        @(posedge clock);
        timerVectorAck <= 2'h0;
        extIrqAck      <= 2'h0;
    endtask : ack

    // Runs timer A for k cycles between the two run bit writes.
    task automatic run_for(input int k);
        bw(3'h4, 1'b1);
        cyc(k - 2);
        bw(3'h4, 1'b0);
    endtask : run_for

    // Counts gained by timer A over a window of k cycles.
    task automatic meas(input int k, input logic [7:0] e);
        rd(ADDR_A_LO, lo0);
        run_for(k);
        rd(ADDR_A_LO, lo1);
        chk(lo1 - lo0, e);
    endtask : meas

    // Counts gained by timer A over n pin pulses of the given hold.
    task automatic cnt(input int n, input int hold);
        rd(ADDR_A_LO, lo0);
        bw(3'h4, 1'b1);
        repeat (n) pin_source_i.pulse(0, hold);
        bw(3'h4, 1'b0);
        rd(ADDR_A_LO, lo1);
        chk(lo1 - lo0, n[7:0]);
    endtask : cnt

    // Main sequence.
    initial begin
        nrst = 1'b0;
        regReq = '0;
        bitReq = '0;
        compatMode = 1'b0;
        doubleSpeed = 1'b0;
        timerVectorAck = 2'h0;
        extIrqAck = 2'h0;
        cyc(8);
        nrst <= 1'b1;
        rc(ADDR_CTRL, 8'h00);
        rc(ADDR_CLKCFG, 8'h05);
        rc(8'h90, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_A_RLO + 8'(i), 8'ha5 + 8'(i));
            rc(ADDR_A_RLO + 8'(i), 8'ha5 + 8'(i));
        end
        wr(ADDR_MODE, 8'h01);
        for (int i = 0; i < 5; i++) begin
            compatMode <= cm[i];
            doubleSpeed <= ds[i];
            wr(ADDR_CLKCFG, cf[i]);
            meas(kk[i], ex[i]);
        end
        rd(ADDR_A_LO, lo0);
        cyc(20);
        rc(ADDR_A_LO, lo0);
        compatMode <= 1'b0;
        wr(ADDR_CLKCFG, 8'h05);
        wr(ADDR_MODE, 8'h05);
        cnt(3, 1);
        compatMode <= 1'b1;
        cnt(2, 6);
        compatMode <= 1'b0;
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_EXT, 8'h01);
        wr(ADDR_A_LO, 8'hfe);
        wr(ADDR_A_HI, 8'hff);
        run_for(4);
        chk(overflowFlag[0], 1'b1);
        chk(togglePin[0], 1'b1);
        rc(ADDR_CTRL, 8'h20);
        ack(2'h1, 2'h0);
        cyc(1);
        chk(overflowFlag[0], 1'b0);
        wr(ADDR_MODE, 8'h09);
        pin_source_i.gate(0, 1'b0, 1);
        meas(20, 8'h00);
        pin_source_i.gate(0, 1'b1, 1);
        meas(20, 8'h14);
        bw(3'h0, 1'b1);
        ack(2'h0, 2'h1);
        cyc(2);
        chk(extIrqFlag[0], 1'b0);
        pin_source_i.gate(0, 1'b0, 2);
        cyc(1);
        chk(extIrqFlag[0], 1'b1);
        pin_source_i.gate(0, 1'b1, 1);
        ack(2'h0, 2'h1);
        bw(3'h0, 1'b0);
        cyc(2);
        chk(extIrqFlag[0], 1'b0);
        pin_source_i.gate(0, 1'b0, 3);
        chk(extIrqFlag[0], 1'b1);
        pin_source_i.gate(1, 1'b0, 2);
        chk(extIrqFlag[1], 1'b1);
        // Timer B overflows once, reloads and toggles its pin.
        wr(ADDR_MODE, 8'h10);
        wr(ADDR_EXT, 8'h02);
        wr(ADDR_B_LO, 8'hff);
        wr(ADDR_B_HI, 8'hff);
        bw(3'h6, 1'b1);
        bw(3'h6, 1'b0);
        cyc(1);
        chk(overflowFlag, 2'h2);
        chk(togglePin, 2'h3);
        rc(ADDR_B_HI, 8'ha8);
        rc(ADDR_B_LO, 8'ha7);
        ack(2'h2, 2'h0);
        cyc(1);
        chk(overflowFlag[1], 1'b0);
        // PWM A steps every clock; half of 256 steps stay high.
        wr(ADDR_A_RHI, 8'h00);
        wr(ADDR_A_RLO, 8'h80);
        wr(ADDR_EXT, 8'h04);
        nHigh = 0;
        repeat (256) begin
            cyc(1);
            nHigh += pwmPin[0];
        end
        chk(8'(nHigh), 8'h80);
        // Mode 0 carries from the five-bit low byte into the high byte.
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_A_LO, 8'h1f);
        wr(ADDR_A_HI, 8'h10);
        run_for(2);
        rc(ADDR_A_HI, 8'h11);
        rc(ADDR_A_LO, 8'h01);
        // Mode 2 reloads the low byte from the high byte.
        wr(ADDR_MODE, 8'h02);
        wr(ADDR_A_LO, 8'hff);
        wr(ADDR_A_HI, 8'h40);
        run_for(4);
        rc(ADDR_A_LO, 8'h43);
        wrap_up();
    end
endmodule : dual_timer_counter_core_tb
`default_nettype wire
